// *** bench/sbdec_bus_model.sv ***
`timescale 1ns/1ps
module sbdec_bus_model (
    input  wire logic dut_o,
    input  wire logic dut_oe,
    output logic      bus_clk,
    output logic      bus_line
);
    logic        drv_val;
    logic [95:0] rx_bits;
    logic [95:0] rx_oe;
    assign bus_line = dut_oe ? dut_o : drv_val;
    initial begin
        bus_clk = 1'b1;
        drv_val = 1'b0;
    end
    // master slots 0x10..0x3f driven, released slots show inverse
    task automatic frame(input logic [95:0] tx);
        for (int a = 0; a < 96; a++) begin
            bus_clk = 1'b0;
            drv_val = (a >= 16 && a < 64) ? tx[a] : ~bus_line;
            #62.5;
            rx_bits[a] = bus_line;
            rx_oe[a]   = dut_oe;
            bus_clk = 1'b1;
            #62.5;
        end
        drv_val = ~drv_val;
        #800;  // sync, clock held high
    endtask
endmodule // sbdec_bus_model

// *** bench/sbdec_checker.sv ***
`timescale 1ns/1ps
module sbdec_checker (
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        bus_clk_i,
    input wire logic        bus_data_oe,
    input wire logic [7:0]  deb_sig,
    input wire logic [15:0] word_out,
    input wire logic        fault_o
);
    logic [7:0] quiet_r;
    logic       pin_r;
    // cycles since the last link clock pin edge, saturating
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            quiet_r <= 8'hff;
            pin_r   <= 1'b1;
        end else begin
            pin_r <= bus_clk_i;
            if (pin_r != bus_clk_i)
                quiet_r <= 8'h00;
            else if (quiet_r != 8'hff)
                quiet_r <= quiet_r + 8'h01;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_next_cycle: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered");
    a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i & wb_stb_i))
        else $error("ack without request");
    a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_sync_no_drive: assert property (quiet_r > 8'd72 |-> !bus_data_oe)
        else $error("line driven during sync");
    a_drive_in_slot: assert property ($rose(bus_data_oe) |-> quiet_r < 8'd10)
        else $error("drive starts away from a clock edge");
    a_deb_at_frame: assert property (
        !$stable(deb_sig) |-> quiet_r > 8'd55) else $error("bits moved");
    a_word_at_frame: assert property (
        !$stable(word_out) |-> quiet_r > 8'd55) else $error("word moved");
    a_fault_at_frame: assert property (
        !$stable(fault_o) |-> quiet_r > 8'd55) else $error("fault moved");
endmodule // sbdec_checker

bind sbdec_top sbdec_checker u_chk (.*);

// *** bench/tb.sv ***
`timescale 1ns/1ps
module tb
    import sbdec_pkg::*;
;
    logic        clock, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic        bus_clk_i, bus_data_i, bus_data_o, bus_data_oe, fault_o;
    logic        fault_m;
    logic [6:0]  pat;
    logic [3:0]  wb_sel_i;
    logic [7:0]  wb_adr_i, deb_sig, h0, h1, h2, deb_m, same, bits;
    logic [15:0] word_out, wm, dflt, w;
    logic [31:0] wb_dat_i, wb_dat_o, q, ctrl;
    int          mismatches, check_count, cyc_n, rides, idx;
    sbdec_top #(.LOSS_CYCLES(2000)) DUT (.*);
    sbdec_bus_model bm (.dut_o(bus_data_o), .dut_oe(bus_data_oe),
                        .bus_clk(bus_clk_i), .bus_line(bus_data_i));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc_n++;
        if (cyc_n == 95000) begin
            mismatches++;
            report_and_stop();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_sel_i <= 4'hf;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clock);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic set_ctrl(input logic [31:0] v);
        wb(1'b1, CTRL_OFS, v);
        ctrl = v;
    endtask
    // one frame with debounce and word model update
    task automatic run_frame(input logic [7:0] b, input logic [15:0] c);
        logic f0;
        f0 = fault_m;
        bm.frame({32'h0, c, w, 8'h00, b, 16'h0000});
        h2 = h1;
        h1 = h0;
        h0 = b;
        same = ctrl[1:0] == DEB_OFF ? 8'hff : ~(h0 ^ h1);
        if (ctrl[1:0] == DEB_THREE)
            same = same & ~(h1 ^ h2);
        deb_m = (deb_m & ~same) | (h0 & same);
        if (ctrl[12] ? c[7:0] === ~w[7:0] : c === ~w) begin
            wm = ctrl[12] ? {wm[15:8], w[7:0]} : w;
            fault_m = 1'b0;
            rides = 0;
        end else begin
            rides++;
            if (!ctrl[9] || rides >= RIDE_MAX) begin
                wm = dflt;
                fault_m = 1'b1;
            end
        end
        check(deb_sig, deb_m);
        check(word_out, wm);
        check(fault_o, fault_m);
        check(bm.rx_bits[9], f0);
    endtask
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = '0;
        {h0, h1, h2, deb_m, wm, dflt, fault_m} = '0;
        {rides, bits, ctrl, pat} = {32'd0, 8'h00, CTRL_RST, 7'b0111011};
        sys_rst = 1'b1;
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        void'($urandom(32'h3a8cc869));
        check(deb_sig, 0);
        check(word_out, DFLT_RST);
        wb(1'b1, 8'h20, 32'hffffffff);
        for (int i = 0; i < 4; i++) begin
            wb(1'b0, i == 3 ? 8'h20 : 8'(i * 4), 0);
            check(q, 0);
        end
        $display("test reset done");
        dflt = 16'($urandom);
        wb(1'b1, DFLT_OFS, {16'h0, dflt});
        for (int l = 0; l < 3; l++) begin
            set_ctrl(32'h100 | (l == 0 ? DEB_OFF : l == 1 ? DEB_TWO : DEB_THREE));
            repeat (6) begin
                bits = bits ^ (8'($urandom) & 8'($urandom));
                w = 16'($urandom);
                run_frame(bits, ~w);
            end
        end
        $display("test debounce done");
        for (int m = 0; m < 3; m++) begin
            set_ctrl(m == 2 ? 32'h1100 : 32'h100 | m << 9);
            for (int i = 0; i < 7; i++) begin
                w = 16'($urandom);
                run_frame(bits, pat[i] ? ~w ^ (16'h1 << ($urandom % 16))
                                       : ~w);
            end
        end
        $display("test word check done");
        for (int inv = 0; inv < 3; inv++) begin
            idx = $urandom % 4;
            set_ctrl(inv < 2 ? 32'h108 | inv << 4 | idx << 6 | 5 << 13
                             : 32'h138 | idx << 6 | (16 + idx) << 13);
            bits = 8'($urandom);
            w = 16'($urandom);
            run_frame(bits, ~w);
            run_frame(bits, ~w);
            if (inv < 2) begin
                check(bm.rx_bits[5], bits[idx] ^ inv[0]);
                check(bm.rx_oe[5], 1);
            end else begin
                check(bm.rx_oe[16 + idx], 0);
                check(bm.rx_bits[16 + idx], bits[idx]);
            end
        end
        $display("test echo done");
        w = 16'($urandom);
        wb(1'b1, TXWD_OFS, {16'h0, ~w});
        set_ctrl(32'hd00);
        run_frame(bits, ~w);
        check(bm.rx_bits[79:64], 16'(~w));
        check(bm.rx_bits[95:80], w);
        set_ctrl(32'h900);
        run_frame(bits, ~w);
        check(bm.rx_oe[95:80], 0);
        $display("test transmit done");
        repeat (2500) @(posedge clock);
        check(deb_sig, 0);
        check(word_out, dflt);
        {h0, h1, h2, deb_m} = '0;
        run_frame(bits, ~w);
        $display("test clock loss done");
        report_and_stop();
    end
endmodule // tb

// *** logic/sbdec_pkg.sv ***
// Functional notes
// (R1) debounce ignores momentary single-bit deviations
// (R2) disagreeing history holds internal signal state
// (R3) change only after debounce-length equal frames
// (R4) debounce length selectable 2, 3 or off
// (R5) after init signals stay default until debounced
// (R6) optional echo of received bit as input
// (R7) echoed bit may be inverted
// (R8) peer mode never echoes to same address
// (R9) sender compares echo, response is application's
// (R10) word accepted only if check copy matches
// (R11) check per byte or word, rx/tx independent
// (R12) device sends check data with its word
// (R13) device verifies check and responds to errors
// (R14) multi-bit output device uses complement checking
// (R15) ride-through option and selectable default output
// (R16) check errors reported on input signal 9
// (R17) check transmission enabled by address allocation
// (R18) error when received check differs from computed
// (R19) default: error forces outputs to default now
// (R20) ride-through holds last value, fault after 3
// (R21) one valid transmission clears fault and count
// (R22) history advances once per frame at sync
package sbdec_pkg;
    localparam int unsigned CLK_NS      = 8;
    localparam int unsigned SYNC_NS     = 500;
    localparam int unsigned SYNC_CYC    = (SYNC_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned LOSS_NS     = 1700000;
    localparam int unsigned LOSS_CYC    = LOSS_NS / CLK_NS;
    localparam int unsigned RIDE_MAX    = 3;
    localparam int unsigned NBITS       = 8;
    // frame slot addresses
    localparam logic [6:0]  RX_BIT_BASE = 7'h10;
    localparam logic [6:0]  RX_WD_BASE  = 7'h20;
    localparam logic [6:0]  RX_CK_BASE  = 7'h30;
    localparam logic [6:0]  TX_WD_BASE  = 7'h40;
    localparam logic [6:0]  TX_CK_BASE  = 7'h50;
    localparam logic [6:0]  FAULT_ADDR  = 7'h09;
    // register offsets
    localparam logic [7:0]  CTRL_OFS    = 8'h00;
    localparam logic [7:0]  DFLT_OFS    = 8'h04;
    localparam logic [7:0]  TXWD_OFS    = 8'h08;
    localparam logic [7:0]  STAT_OFS    = 8'h0c;
    localparam logic [7:0]  RXWD_OFS    = 8'h10;
    localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
    localparam logic [15:0] DFLT_RST    = 16'h0000;
    localparam logic [15:0] TXWD_RST    = 16'h0000;
    // debounce length codes
    localparam logic [1:0]  DEB_OFF     = 2'h0;
    localparam logic [1:0]  DEB_TWO     = 2'h2;
    localparam logic [1:0]  DEB_THREE   = 2'h3;

    typedef struct packed {
        logic [11:0] unused;
        logic [6:0]  echo_addr;  // [19:13]
        logic        cdr_byte;   // [12] per-byte check
        logic        cdr_tx_en;  // [11]
        logic        alloc32;    // [10]
        logic        ride_en;    // [9]
        logic        cdr_rx_en;  // [8]
        logic [1:0]  echo_sel;   // [7:6] echoed bit index low
        logic        p2p;        // [5]
        logic        echo_inv;   // [4]
        logic        echo_en;    // [3]
        logic        deb_hi;     // [2] unused pad
        logic [1:0]  deb_len;    // [1:0]
    } sbdec_ctrl_s;

    typedef enum logic [0:0] {LS_LOST, LS_RUN} sbdec_link_e;
endpackage

// *** logic/sbdec_top.sv ***
// Register access over Wishbone and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module sbdec_top
    import sbdec_pkg::*;
#(
    parameter int unsigned LOSS_CYCLES = LOSS_CYC
) (
    input  wire logic              clock,
    input  wire logic              sys_rst,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic              bus_clk_i,
    input  wire logic              bus_data_i,
    output logic                   bus_data_o,
    output logic                   bus_data_oe,
    output logic      [NBITS-1:0]  deb_sig,
    output logic      [15:0]       word_out,
    output logic                   fault_o
);
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    sbdec_ctrl_s ctrl_r;
    logic [15:0] dflt_r;
    logic [15:0] txwd_r;
    logic [15:0] acc_r;
    logic [1:0]  ride_r;
    logic        cdr_err_r;

    // pin synchronisers
    logic [1:0] clk_s_r;
    logic [1:0] dat_s_r;
    logic       clk_prev_r;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            // link clock idles high: no false edge after reset
            clk_s_r    <= 2'h3;
            dat_s_r    <= 2'h0;
            clk_prev_r <= 1'b1;
        end else begin
            clk_s_r    <= {clk_s_r[0], bus_clk_i};
            dat_s_r    <= {dat_s_r[0], bus_data_i};
            clk_prev_r <= clk_s_r[1];
        end
    end
    logic rise;
    logic fall;
    assign rise = clk_s_r[1] & ~clk_prev_r;
    assign fall = ~clk_s_r[1] & clk_prev_r;

    // frame timing: sync period and clock loss
    logic [31:0] idle_r;
    logic        in_sync_r;
    logic        frame_end;
    sbdec_link_e link_r;
    logic [6:0]  addr_r;
    assign frame_end = (idle_r == 32'(SYNC_CYC)) && (link_r == LS_RUN);
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            idle_r    <= 32'h0;
            in_sync_r <= 1'b0;
            link_r    <= LS_LOST;
            addr_r    <= 7'h0;
        end else begin
            if (rise || fall) begin
                idle_r <= 32'h0;
            end else if (idle_r != 32'(LOSS_CYCLES)) begin
                idle_r <= idle_r + 32'h1;
            end
            if (idle_r == 32'(LOSS_CYCLES)) begin
                link_r <= LS_LOST;
            end else if (fall) begin
                link_r <= LS_RUN;
            end
            if (frame_end) begin
                in_sync_r <= 1'b1;
                addr_r    <= 7'h0;
            end else if (rise) begin
                in_sync_r <= 1'b0;
                addr_r    <= addr_r + 7'h1;
            end
        end
    end

    // received slots, sampled on link clock rise
    logic [NBITS-1:0] rxb_r;
    logic [15:0]      rxw_r;
    logic [15:0]      rxc_r;
    logic [6:0]       off_w;
    logic [6:0]       off_c;
    assign off_w = addr_r - RX_WD_BASE;
    assign off_c = addr_r - RX_CK_BASE;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rxb_r <= '0;
            rxw_r <= 16'h0;
            rxc_r <= 16'h0;
        end else if (rise) begin
            if (addr_r >= RX_BIT_BASE && addr_r < RX_BIT_BASE + 7'(NBITS)) begin
                rxb_r[3'(addr_r - RX_BIT_BASE)] <= dat_s_r[1];
            end else if (addr_r >= RX_WD_BASE && off_w < 7'h10) begin
                rxw_r[off_w[3:0]] <= dat_s_r[1];
            end else if (addr_r >= RX_CK_BASE && off_c < 7'h10) begin
                rxc_r[off_c[3:0]] <= dat_s_r[1];
            end
        end
    end

    // per-bit debounce
    logic [1:0] hist_r [NBITS];
    logic       lost;
    assign lost = (link_r == LS_LOST);
    generate
        for (genvar i = 0; i < NBITS; i++) begin : g_deb
            logic nb;
            assign nb = rxb_r[i];
            always_ff @(posedge clock or posedge sys_rst) begin
                if (sys_rst) begin
                    hist_r[i]  <= 2'h0;
                    deb_sig[i] <= 1'b0;
                end else if (lost) begin
                    hist_r[i]  <= 2'h0; // R5
                    deb_sig[i] <= 1'b0; // R5
                end else if (frame_end) begin
                    hist_r[i] <= {hist_r[i][0], nb}; // R22
                    case (ctrl_r.deb_len)
                        DEB_OFF: deb_sig[i] <= nb; // R4
                        DEB_TWO: begin
                            if (nb == hist_r[i][0]) begin
                                deb_sig[i] <= nb; // R2 R3
                            end
                        end
                        DEB_THREE: begin
                            if (nb == hist_r[i][0] && nb == hist_r[i][1]) begin
                                deb_sig[i] <= nb; // R1 R3
                            end
                        end
                        default: deb_sig[i] <= deb_sig[i];
                    endcase
                end
            end
        end
    endgenerate

    // complement check on received word
    logic [1:0] ok;
    logic       good;
    assign ok[0] = (rxc_r[7:0] == ~rxw_r[7:0]); // R18
    assign ok[1] = (rxc_r[15:8] == ~rxw_r[15:8]); // R18
    assign good  = ctrl_r.cdr_byte ? ok[0] : &ok; // R11
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            word_out  <= 16'h0;
            acc_r     <= 16'h0;
            ride_r    <= 2'h0;
            fault_o   <= 1'b0;
            cdr_err_r <= 1'b0;
        end else if (lost) begin
            word_out <= dflt_r; // R19
            ride_r   <= 2'h0;
            fault_o  <= 1'b0;
        end else if (frame_end) begin
            if (!ctrl_r.cdr_rx_en || good) begin
                word_out  <= ctrl_r.cdr_byte
                           ? {word_out[15:8], rxw_r[7:0]} : rxw_r; // R10
                acc_r     <= rxw_r;
                ride_r    <= 2'h0; // R21
                fault_o   <= 1'b0; // R21
                cdr_err_r <= 1'b0;
            end else begin
                cdr_err_r <= 1'b1; // R13 R14
                if (!ctrl_r.ride_en) begin
                    word_out <= dflt_r; // R15 R19
                    fault_o  <= 1'b1;
                end else if (ride_r == 2'(RIDE_MAX - 1)) begin
                    word_out <= dflt_r; // R20
                    fault_o  <= 1'b1; // R20
                end else begin
                    ride_r <= ride_r + 2'h1; // R20
                end
            end
        end
    end

    // transmit slots: fault flag, echo, own word with check
    logic       echo_ok;
    logic       echo_bit;
    logic [6:0] off_tw;
    logic [6:0] off_tc;
    logic [2:0] echo_idx;
    assign echo_idx = {1'b0, ctrl_r.echo_sel};
    assign echo_ok  = ctrl_r.echo_en && !(ctrl_r.p2p
                    && ctrl_r.echo_addr == RX_BIT_BASE + 7'(echo_idx)); // R8
    assign echo_bit = deb_sig[echo_idx] ^ ctrl_r.echo_inv; // R6 R7
    assign off_tw   = addr_r - TX_WD_BASE;
    assign off_tc   = addr_r - TX_CK_BASE;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            bus_data_o  <= 1'b0;
            bus_data_oe <= 1'b0;
        end else if (lost || in_sync_r) begin
            bus_data_o  <= 1'b0;
            bus_data_oe <= 1'b0;
        end else begin
            bus_data_oe <= 1'b0;
            bus_data_o  <= 1'b0;
            if (addr_r == FAULT_ADDR && ctrl_r.cdr_rx_en) begin
                bus_data_oe <= 1'b1;
                bus_data_o  <= fault_o; // R16
            end else if (echo_ok && addr_r == ctrl_r.echo_addr) begin
                bus_data_oe <= 1'b1;
                bus_data_o  <= echo_bit; // R6 R7
            end else if (addr_r >= TX_WD_BASE && off_tw < 7'h10) begin
                bus_data_oe <= 1'b1;
                bus_data_o  <= txwd_r[off_tw[3:0]];
            end else if (ctrl_r.cdr_tx_en && ctrl_r.alloc32
                         && addr_r >= TX_CK_BASE && off_tc < 7'h10) begin
                bus_data_oe <= 1'b1;
                bus_data_o  <= ~txwd_r[off_tc[3:0]]; // R12 R17
            end
        end
    end

    // classic wishbone slave
    logic req;
    assign req = wb_cyc_i & wb_stb_i;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
            wb_dat_o <= 32'h0;
            if (req && !wb_ack_o && !wb_we_i) begin
                if (wb_adr_i == CTRL_OFS) begin
                    wb_dat_o <= ctrl_r;
                end else if (wb_adr_i == DFLT_OFS) begin
                    wb_dat_o <= {16'h0, dflt_r};
                end else if (wb_adr_i == TXWD_OFS) begin
                    wb_dat_o <= {16'h0, txwd_r};
                end else if (wb_adr_i == STAT_OFS) begin
                    wb_dat_o <= {19'h0, link_r == LS_RUN, cdr_err_r,
                                 ride_r, fault_o, deb_sig};
                end else if (wb_adr_i == RXWD_OFS) begin
                    wb_dat_o <= {16'h0, acc_r};
                end
            end
        end
    end

    logic wr;
    assign wr = req & wb_ack_o & wb_we_i;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_r <= CTRL_RST;
            dflt_r <= DFLT_RST;
            txwd_r <= TXWD_RST;
        end else if (wr) begin
            if (wb_adr_i == CTRL_OFS) begin
                ctrl_r <= merge(ctrl_r, wb_dat_i, wb_sel_i) & 32'h000f_ffff;
            end else if (wb_adr_i == DFLT_OFS) begin
                dflt_r <= 16'(merge({16'h0, dflt_r}, wb_dat_i, wb_sel_i)); // R15
            end else if (wb_adr_i == TXWD_OFS) begin
                txwd_r <= 16'(merge({16'h0, txwd_r}, wb_dat_i, wb_sel_i));
            end
        end
    end
endmodule // sbdec_top
